// *** inc/scpc_pkg.sv ***
package scpc_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam logic [11:0] OFF_POWER_CAL_CTRL = 12'h0280;
  localparam logic [11:0] OFF_STATE_FLAGS = 12'h0281;
  localparam logic [11:0] OFF_REF_DIVIDER = 12'h0289;
  localparam logic [11:0] OFF_TERM_CAL_A = 12'h02a7;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int POS_POWER_ENABLE = 0;
  localparam int POS_CTRL_SPARE = 1;
  localparam int POS_RECAL_TRIGGER = 2;
  localparam int POS_LOCKED = 0;
  localparam int POS_CAL_DONE = 3;
  localparam int POS_BELOW = 4;
  localparam int POS_ABOVE = 5;
  localparam int POS_TERM_START = 0;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_POWER_CAL_CTRL = 8'h00;
  localparam logic [7:0] RST_STATE_FLAGS = 8'h00;
  localparam logic [1:0] RST_REF_DIVIDER = 2'h0;
  localparam logic [7:0] RST_TERM_CAL_A = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // ------------------------------------------------------------
  // Reference predivide codes
  // ------------------------------------------------------------
  localparam logic [1:0] DIV_CODE_BY4 = 2'h0;
  localparam logic [1:0] DIV_CODE_BY2 = 2'h1;
  localparam logic [1:0] DIV_CODE_BY1 = 2'h2;
  localparam int DIV_CNT_W = 2;

  // Code 3 is unassigned; it falls back to the pass-through ratio
  function automatic logic [1:0] div_last(input logic [1:0] code);
    case (code)
      DIV_CODE_BY4: div_last = 2'h3;
      DIV_CODE_BY2: div_last = 2'h1;
      default: div_last = 2'h0;
    endcase
  endfunction

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int BIAS_SETTLE_NS = 1000;
  localparam int BIAS_SETTLE_CYC =
    (BIAS_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BIAS_CNT_W = 8;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SEQ_OFF = 2'b00,
    SEQ_BIAS = 2'b01,
    SEQ_CAL = 2'b10,
    SEQ_RUN = 2'b11
  } scpc_seq_e;

  typedef struct packed {
    logic above;
    logic below;
    logic cal_done;
    logic locked;
  } scpc_flags_s;

endpackage

// *** hdl/scpc_ref_div.sv ***
`timescale 1ns/1ns
module scpc_ref_div #(
  parameter int CNT_W = scpc_pkg::DIV_CNT_W
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic run_i,
  input wire logic [1:0] code_i,
  output logic pfd_tick_o
);

  initial begin
    if (CNT_W < 2) begin
      $error("scpc_ref_div: counter too narrow for divide by 4");
    end
  end

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] last;
  logic tick_q;

  assign last = CNT_W'(scpc_pkg::div_last(code_i));

  // One reference tick out of every 1, 2 or 4 clock cycles
  always_ff @(posedge clk_i) begin
    if (srst_i || !run_i) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (cnt_q >= last) begin
      cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
      tick_q <= 1'b0;
    end
  end

  assign pfd_tick_o = tick_q;

endmodule

// *** hdl/scpc_ctrl.sv ***
`timescale 1ns/1ns
module scpc_ctrl #(
  parameter int BIAS_CYC = scpc_pkg::BIAS_SETTLE_CYC
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic pump_above_i,
  input wire logic pump_below_i,
  input wire logic pump_cal_valid_i,
  input wire logic synth_lock_i,
  output logic pll_bias_en_o,
  output logic pll_cal_start_o,
  output logic term_cal_start_o,
  output logic pfd_tick_o
);

  initial begin
    if (BIAS_CYC < 1 || BIAS_CYC >= (1 << scpc_pkg::BIAS_CNT_W)) begin
      $error("scpc_ctrl: bias settle count out of range");
    end
  end

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  logic power_enable_q;
  logic ctrl_spare_q;
  logic recal_trigger_q;
  logic [1:0] predivide_q;
  logic term_start_q;
  logic wr_ctrl;
  logic wr_div;
  logic wr_term;

  assign wr_ctrl = reg_wr_i && reg_addr_i == scpc_pkg::OFF_POWER_CAL_CTRL;
  assign wr_div = reg_wr_i && reg_addr_i == scpc_pkg::OFF_REF_DIVIDER;
  assign wr_term = reg_wr_i && reg_addr_i == scpc_pkg::OFF_TERM_CAL_A;

  // Writes to the flag register and reserved bits have no target
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      power_enable_q <=
        scpc_pkg::RST_POWER_CAL_CTRL[scpc_pkg::POS_POWER_ENABLE];
      ctrl_spare_q <= scpc_pkg::RST_POWER_CAL_CTRL[scpc_pkg::POS_CTRL_SPARE];
      recal_trigger_q <=
        scpc_pkg::RST_POWER_CAL_CTRL[scpc_pkg::POS_RECAL_TRIGGER];
    end else if (wr_ctrl) begin
      power_enable_q <= reg_wdata_i[scpc_pkg::POS_POWER_ENABLE];
      ctrl_spare_q <= reg_wdata_i[scpc_pkg::POS_CTRL_SPARE];
      recal_trigger_q <= reg_wdata_i[scpc_pkg::POS_RECAL_TRIGGER];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      predivide_q <= scpc_pkg::RST_REF_DIVIDER;
    end else if (wr_div) begin
      predivide_q <= reg_wdata_i[1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      term_start_q <= scpc_pkg::RST_TERM_CAL_A[scpc_pkg::POS_TERM_START];
    end else if (wr_term) begin
      term_start_q <= reg_wdata_i[scpc_pkg::POS_TERM_START];
    end
  end

  // ------------------------------------------------------------
  // Edge detection on trigger bits
  // ------------------------------------------------------------
  logic recal_prev_q;
  logic term_prev_q;
  logic recal_rise;
  logic term_rise;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      recal_prev_q <= 1'b0;
      term_prev_q <= 1'b0;
    end else begin
      recal_prev_q <= recal_trigger_q;
      term_prev_q <= term_start_q;
    end
  end

  // Holding the bit high does nothing more; software must drop it first
  assign recal_rise = recal_trigger_q && !recal_prev_q;
  assign term_rise = term_start_q && !term_prev_q;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      term_cal_start_o <= 1'b0;
    end else begin
      term_cal_start_o <= term_rise;
    end
  end

  // ------------------------------------------------------------
  // Analog status synchronisers
  // ------------------------------------------------------------
  logic [3:0] meta_q;
  logic [3:0] sync_q;
  scpc_pkg::scpc_flags_s raw;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta_q <= 4'h0;
      sync_q <= 4'h0;
    end else begin
      meta_q <= {pump_above_i, pump_below_i, pump_cal_valid_i, synth_lock_i};
      sync_q <= meta_q;
    end
  end

  assign raw = scpc_pkg::scpc_flags_s'(sync_q);

  // ------------------------------------------------------------
  // Power and calibration sequencer
  // ------------------------------------------------------------
  scpc_pkg::scpc_seq_e seq_q;
  logic [scpc_pkg::BIAS_CNT_W-1:0] bias_cnt_q;
  logic bias_done;

  assign bias_done = bias_cnt_q == scpc_pkg::BIAS_CNT_W'(BIAS_CYC - 1);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      seq_q <= scpc_pkg::SEQ_OFF;
    end else if (!power_enable_q) begin
      seq_q <= scpc_pkg::SEQ_OFF;
    end else begin
      case (seq_q)
        scpc_pkg::SEQ_OFF: begin
          seq_q <= scpc_pkg::SEQ_BIAS;
        end
        scpc_pkg::SEQ_BIAS: begin
          if (bias_done) begin
            seq_q <= scpc_pkg::SEQ_CAL;
          end
        end
        scpc_pkg::SEQ_CAL: begin
          if (recal_rise) begin
            seq_q <= scpc_pkg::SEQ_CAL;
          end else if (raw.cal_done && !pll_cal_start_o) begin
            seq_q <= scpc_pkg::SEQ_RUN;
          end
        end
        scpc_pkg::SEQ_RUN: begin
          if (recal_rise) begin
            seq_q <= scpc_pkg::SEQ_CAL;
          end
        end
        default: begin
          seq_q <= scpc_pkg::SEQ_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i || seq_q != scpc_pkg::SEQ_BIAS) begin
      bias_cnt_q <= '0;
    end else if (!bias_done) begin
      bias_cnt_q <= bias_cnt_q + scpc_pkg::BIAS_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pll_bias_en_o <= 1'b0;
    end else begin
      pll_bias_en_o <= power_enable_q;
    end
  end

  // A recal edge while the bias is still settling is ignored; the sequence starts calibration on its own
  always_ff @(posedge clk_i) begin
    if (srst_i || !power_enable_q) begin
      pll_cal_start_o <= 1'b0;
    end else begin
      pll_cal_start_o <= (seq_q == scpc_pkg::SEQ_BIAS && bias_done) ||
        ((seq_q == scpc_pkg::SEQ_CAL || seq_q == scpc_pkg::SEQ_RUN) &&
        recal_rise);
    end
  end

  // ------------------------------------------------------------
  // Status flags
  // ------------------------------------------------------------
  scpc_pkg::scpc_flags_s flags_q;
  logic powered;

  assign powered = seq_q != scpc_pkg::SEQ_OFF;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      flags_q <= scpc_pkg::scpc_flags_s'(4'h0);
    end else begin
      flags_q.above <= raw.above && powered;
      flags_q.below <= raw.below && powered;
      flags_q.cal_done <= raw.cal_done && seq_q == scpc_pkg::SEQ_RUN;
      flags_q.locked <= raw.locked && seq_q == scpc_pkg::SEQ_RUN;
    end
  end

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = scpc_pkg::RD_UNMAPPED;
    case (reg_addr_i)
      scpc_pkg::OFF_POWER_CAL_CTRL: begin
        rd_mux[scpc_pkg::POS_POWER_ENABLE] = power_enable_q;
        rd_mux[scpc_pkg::POS_CTRL_SPARE] = ctrl_spare_q;
        rd_mux[scpc_pkg::POS_RECAL_TRIGGER] = recal_trigger_q;
      end
      scpc_pkg::OFF_STATE_FLAGS: begin
        rd_mux[scpc_pkg::POS_ABOVE] = flags_q.above;
        rd_mux[scpc_pkg::POS_BELOW] = flags_q.below;
        rd_mux[scpc_pkg::POS_CAL_DONE] = flags_q.cal_done;
        rd_mux[scpc_pkg::POS_LOCKED] = flags_q.locked;
      end
      scpc_pkg::OFF_REF_DIVIDER: begin
        rd_mux[1:0] = predivide_q;
      end
      scpc_pkg::OFF_TERM_CAL_A: begin
        rd_mux[scpc_pkg::POS_TERM_START] = term_start_q;
      end
      default: begin
        rd_mux = scpc_pkg::RD_UNMAPPED;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= scpc_pkg::RD_UNMAPPED;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_mux;
    end
  end

  // ------------------------------------------------------------
  // Reference predivider
  // ------------------------------------------------------------
  scpc_ref_div #(
    .CNT_W(scpc_pkg::DIV_CNT_W)
  ) u_ref_div (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .run_i(powered),
    .code_i(predivide_q),
    .pfd_tick_o(pfd_tick_o)
  );

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  sequence s_recal_edge;
    power_enable_q && !recal_prev_q && recal_trigger_q &&
      seq_q inside {scpc_pkg::SEQ_CAL, scpc_pkg::SEQ_RUN};
  endsequence

  sequence s_enable_rise;
    !power_enable_q ##1 power_enable_q;
  endsequence

  a_recal_starts_cal: assert property (
    s_recal_edge |=> pll_cal_start_o && seq_q == scpc_pkg::SEQ_CAL)
    else $error("recal edge did not restart calibration");

  a_bias_before_cal: assert property (
    s_enable_rise ##1 power_enable_q [*2] |-> pll_bias_en_o &&
      !pll_cal_start_o)
    else $error("bias not on or calibration too early");

  a_enable_runs_cal: assert property (
    (seq_q == scpc_pkg::SEQ_BIAS && bias_done && power_enable_q) |=>
      pll_cal_start_o)
    else $error("calibration not started after bias settle");

  a_above_follows: assert property (
    powered |=> flags_q.above == $past(raw.above))
    else $error("above-range flag does not follow pump");

  a_below_follows: assert property (
    powered |=> flags_q.below == $past(raw.below))
    else $error("below-range flag does not follow pump");

  a_cal_done_gate: assert property (
    flags_q.cal_done |-> $past(raw.cal_done) &&
      $past(seq_q) == scpc_pkg::SEQ_RUN)
    else $error("cal done flag without completed calibration");

  a_lock_reset: assert property (
    $fell(srst_i) |-> !flags_q.locked)
    else $error("lock flag not zero after reset");

  a_div_by1: assert property (
    (powered && predivide_q == scpc_pkg::DIV_CODE_BY1) [*4] |-> pfd_tick_o)
    else $error("divide by 1 code does not tick every cycle");

  a_div_by4: assert property (
    pfd_tick_o && powered && predivide_q == scpc_pkg::DIV_CODE_BY4 ##1
      (powered && predivide_q == scpc_pkg::DIV_CODE_BY4) [*3] |->
      !$past(pfd_tick_o) && !$past(pfd_tick_o, 2) && !pfd_tick_o)
    else $error("divide by 4 ticks too often");

  a_term_pulse: assert property (
    (term_start_q && !term_prev_q) |=> term_cal_start_o ##1
      !term_cal_start_o)
    else $error("termination calibration start not a single pulse");

  a_flags_ro: assert property (
    reg_wr_i && reg_addr_i == scpc_pkg::OFF_STATE_FLAGS |=>
      $stable(power_enable_q) && $stable(predivide_q))
    else $error("flag register write changed control state");

endmodule

// *** tb/tb_serdes_pll_control_status.sv ***
`timescale 1ns/1ns
module tb_serdes_pll_control_status;
  // ----------------------------------------------------------
  // Signals
  // ----------------------------------------------------------
  // Short bias settle keeps the run brief
  localparam int BIAS = 4;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [11:0] reg_addr_i = 12'h0000;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] reg_rdata_o;
  logic pump_above_i = 1'b1;
  logic pump_below_i = 1'b1;
  logic pump_cal_valid_i = 1'b1;
  logic synth_lock_i = 1'b1;
  logic pll_bias_en_o;
  logic pll_cal_start_o;
  logic term_cal_start_o;
  logic pfd_tick_o;
  int err_total = 0;
  int compares = 0;
  int edge_n = 0;
  int tick_n = 0;
  int t0;
  logic rd_d = 1'b0;
  logic a;
  logic b;
  logic [7:0] rd_exp[$];
  string rd_nm[$];
  int cal_lo[$];
  int cal_hi[$];
  int term_at[$];

  always #5 clk_i = ~clk_i;

  scpc_ctrl #(.BIAS_CYC(BIAS)) uut (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o),
    .pump_above_i(pump_above_i),
    .pump_below_i(pump_below_i),
    .pump_cal_valid_i(pump_cal_valid_i),
    .synth_lock_i(synth_lock_i),
    .pll_bias_en_o(pll_bias_en_o),
    .pll_cal_start_o(pll_cal_start_o),
    .term_cal_start_o(term_cal_start_o),
    .pfd_tick_o(pfd_tick_o)
  );

  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task automatic give_verdict();
    if (err_total == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_at(string nm, int lo, int hi, int g);
    compares++;
    if (g < lo || g > hi) begin
      err_total++;
      $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wr(logic [11:0] ad, logic [7:0] d);
    cyc(1);
    reg_wr_i = 1'b1;
    reg_addr_i = ad;
    reg_wdata_i = d;
    cyc(1);
    reg_wr_i = 1'b0;
  endtask

  // Expectation is queued before the strobe so the monitor finds it
  task automatic rd(logic [11:0] ad, logic [7:0] e, string nm);
    rd_exp.push_back(e);
    rd_nm.push_back(nm);
    cyc(1);
    reg_rd_i = 1'b1;
    reg_addr_i = ad;
    cyc(1);
    reg_rd_i = 1'b0;
  endtask

  task automatic reset_check();
    rd(scpc_pkg::OFF_POWER_CAL_CTRL, scpc_pkg::RST_POWER_CAL_CTRL, "ctrl");
    rd(scpc_pkg::OFF_STATE_FLAGS, scpc_pkg::RST_STATE_FLAGS, "flags");
    rd(scpc_pkg::OFF_REF_DIVIDER, {6'h00, scpc_pkg::RST_REF_DIVIDER}, "div");
    rd(scpc_pkg::OFF_TERM_CAL_A, scpc_pkg::RST_TERM_CAL_A, "term");
    rd(12'h0282, scpc_pkg::RD_UNMAPPED, "unmapped");
  endtask

  task automatic ticks(logic [7:0] e);
    t0 = tick_n;
    cyc(24);
    chk("pfd_tick_o count", e, 8'(tick_n - t0));
  endtask

  // ----------------------------------------------------------
  // Monitor
  // ----------------------------------------------------------
  // Samples at the edge, so it sees values from the cycle before
  always @(posedge clk_i) begin
    edge_n = edge_n + 1;
    if (pfd_tick_o === 1'b1) tick_n = tick_n + 1;
    if (rd_d) chk(rd_nm.pop_front(), rd_exp.pop_front(), reg_rdata_o);
    rd_d = reg_rd_i;
    if (pll_cal_start_o === 1'b1) begin
      if (cal_lo.size() == 0) chk_at("pll_cal_start_o", -1, -1, edge_n);
      else chk_at("pll_cal_start_o", cal_lo.pop_front(), cal_hi.pop_front(),
        edge_n);
    end
    if (term_cal_start_o === 1'b1) begin
      if (term_at.size() == 0) begin
        chk_at("term_cal_start_o", -1, -1, edge_n);
      end else begin
        chk_at("term_cal_start_o", term_at[0], term_at[0], edge_n);
        void'(term_at.pop_front());
      end
    end
  end

  // ----------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------
  initial begin
    cyc(5000);
    err_total++;
    give_verdict();
  end

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    void'($urandom(32'h4f38));
    cyc(12);
    srst_i = 1'b0;
    reset_check();
    wr(scpc_pkg::OFF_STATE_FLAGS, 8'hff);
    rd(scpc_pkg::OFF_STATE_FLAGS, 8'h00, "flags ro");
    wr(scpc_pkg::OFF_POWER_CAL_CTRL, 8'hfa);
    rd(scpc_pkg::OFF_POWER_CAL_CTRL, 8'h02, "ctrl rsvd");
    wr(scpc_pkg::OFF_REF_DIVIDER, 8'hfe);
    rd(scpc_pkg::OFF_REF_DIVIDER, 8'h02, "div rsvd");
    wr(scpc_pkg::OFF_TERM_CAL_A, 8'hfe);
    rd(scpc_pkg::OFF_TERM_CAL_A, 8'h00, "term rsvd");
    wr(12'h03ff, 8'h55);
    rd(12'h03ff, scpc_pkg::RD_UNMAPPED, "unmapped");
    // Divider is programmed before enabling
    pump_cal_valid_i = 1'b0;
    synth_lock_i = 1'b0;
    wr(scpc_pkg::OFF_REF_DIVIDER,
      {6'h00, scpc_pkg::DIV_CODE_BY4});
    wr(scpc_pkg::OFF_POWER_CAL_CTRL, 8'h01);
    cal_lo.push_back(edge_n + 3);
    cal_hi.push_back(edge_n + BIAS + 8);
    cyc(2);
    chk("pll_bias_en_o", 8'h01, {7'h00, pll_bias_en_o});
    cyc(BIAS + 8);
    pump_cal_valid_i = 1'b1;
    synth_lock_i = 1'b1;
    cyc(6);
    repeat (6) begin
      a = 1'($urandom % 2);
      b = 1'($urandom % 2);
      pump_above_i = a;
      pump_below_i = b;
      cyc(5);
      rd(scpc_pkg::OFF_STATE_FLAGS, {2'b00, a, b, 1'b1, 2'b00, 1'b1},
        "flags");
    end
    synth_lock_i = 1'b0;
    cyc(5);
    rd(scpc_pkg::OFF_STATE_FLAGS, {2'b00, a, b, 4'h8}, "unlock");
    // Second write of a set bit must not retrigger
    // Pulse is launched one edge after the write and seen at the next
    wr(scpc_pkg::OFF_POWER_CAL_CTRL, 8'h05);
    cal_lo.push_back(edge_n + 2);
    cal_hi.push_back(edge_n + 2);
    wr(scpc_pkg::OFF_POWER_CAL_CTRL, 8'h05);
    wr(scpc_pkg::OFF_POWER_CAL_CTRL, 8'h01);
    wr(scpc_pkg::OFF_POWER_CAL_CTRL, 8'h05);
    cal_lo.push_back(edge_n + 2);
    cal_hi.push_back(edge_n + 2);
    wr(scpc_pkg::OFF_POWER_CAL_CTRL, 8'h01);
    wr(scpc_pkg::OFF_TERM_CAL_A, 8'h01);
    term_at.push_back(edge_n + 2);
    rd(scpc_pkg::OFF_TERM_CAL_A, 8'h01, "term bit");
    wr(scpc_pkg::OFF_TERM_CAL_A, 8'h01);
    wr(scpc_pkg::OFF_TERM_CAL_A, 8'h00);
    wr(scpc_pkg::OFF_TERM_CAL_A, 8'h01);
    term_at.push_back(edge_n + 2);
    for (int c = 0; c < 4; c++) begin
      wr(scpc_pkg::OFF_REF_DIVIDER, 8'(c));
      cyc(8);
      if (2'(c) == scpc_pkg::DIV_CODE_BY4) ticks(8'd6);
      else if (2'(c) == scpc_pkg::DIV_CODE_BY2) ticks(8'd12);
      else ticks(8'd24);
    end
    wr(scpc_pkg::OFF_POWER_CAL_CTRL, 8'h00);
    cyc(8);
    ticks(8'd0);
    chk("pll_bias_en_o", 8'h00, {7'h00, pll_bias_en_o});
    rd(scpc_pkg::OFF_STATE_FLAGS, 8'h00, "flags off");
    wr(scpc_pkg::OFF_REF_DIVIDER, 8'h01);
    wr(scpc_pkg::OFF_POWER_CAL_CTRL, 8'h02);
    srst_i = 1'b1;
    cyc(2);
    srst_i = 1'b0;
    reset_check();
    cyc(4);
    chk("pending pulses", 8'h00,
      8'(cal_lo.size() + term_at.size()));
    give_verdict();
  end
endmodule
